// file: prs_defines.svh
// Offsets, field positions, reset values and timing counts of the resource sequencer.
`ifndef PRS_DEFINES_SVH
`define PRS_DEFINES_SVH
// Register word addresses on the plain register port.
`define PRS_ADDR_MIN_SET     8'h00
`define PRS_ADDR_STATUS      8'h01
`define PRS_ADDR_REQ_TIMER   8'h02
`define PRS_ADDR_SLEEP_CTRL  8'h03
`define PRS_ADDR_WAKE_TIMER  8'h04
`define PRS_ADDR_RETAINED    8'h05
`define PRS_ADDR_DEP_BASE    8'h08
`define PRS_ADDR_DELAY_BASE  8'h10
`define PRS_ADDR_CLKMAP_BASE 8'h18
// Field positions.
`define PRS_STAT_PEND_LSB    8
`define PRS_STAT_MODE_LSB    16
`define PRS_REQT_MASK_LSB    16
`define PRS_SLEEP_DOZE_BIT   0
`define PRS_SLEEP_DEEP_BIT   1
// Reset values.
`define PRS_MIN_SET_RST      8'h07
`define PRS_BOOT_SET         8'h07
`define PRS_BASE_SET         8'h01
`define PRS_DEP_RST          8'h01
`define PRS_DLY_ON_RST       16'h0002
`define PRS_DLY_OFF_RST      16'h0001
`define PRS_CLKMAP_RST       8'h06
`define PRS_WAKE_TIMER_RST   16'h0020
// Low-power oscillator rate in Hz and core clock rate in Hz.
`define PRS_LPO_HZ           32768
`define PRS_CORE_HZ          100000000
`endif

// file: prs_host_model.sv
// Host that drives both power-on levels after a chosen lag.
`default_nettype none
module prs_host_model
(
    input  wire logic       core_clk, // Clock.
    input  wire logic [1:0] want,     // Wanted levels, WLAN then radio.
    input  wire logic [3:0] lag,      // Cycles before a change lands.
    output logic            wl_on,    // WLAN power-on.
    output logic            sr_on     // Radio power-on.
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt = 4'h0;
    initial {wl_on, sr_on} = 2'b00;
    // A new level lands after the lag, so the host answers promptly or slowly.
    always @(posedge core_clk)
    begin
        cnt <= ({wl_on, sr_on} == want) ? 4'h0 : cnt + 4'h1;
        if ({wl_on, sr_on} != want && cnt >= lag)
            {wl_on, sr_on} <= want;
    end
endmodule // prs_host_model
`default_nettype wire

// file: prs_pkg.sv
// Types shared by the resource sequencer.
`default_nettype none
package prs_pkg;
    localparam int PRS_NRES  = 8;
    localparam int PRS_NCORE = 2;

    // Power mode of the chip as seen by the sequencer.
    typedef enum logic [2:0] {
        PRS_OFF,
        PRS_ACTIVE,
        PRS_DOZE,
        PRS_SAVE,
        PRS_DEEP,
        PRS_RESTORE
    } prs_mode_t;

    // Enables of the three main regulators.
    typedef struct packed {
        logic core_switching_regulator;
        logic core_linear_regulator;
        logic low_noise_linear_regulator;
    } prs_regulator_t;

    // Per-resource transition delays in low-power clock ticks.
    typedef struct packed {
        logic [15:0] disable_delay;
        logic [15:0] enable_delay;
    } prs_delay_t;

    // Requests that wake the chip from a sleep mode.
    typedef struct packed {
        logic timer_expired;
        logic external_irq;
        logic host_resume;
    } prs_wake_t;
endpackage
`default_nettype wire

// file: prs_resource_sequencer.sv
// Resource sequencer: power-on control, resource state machine, sleep modes and registers.
//
// The address-and-strobe port and the address map are this design's own decisions.
`default_nettype none
`include "prs_defines.svh"

module prs_resource_sequencer
    import prs_pkg::*;
(
    input  wire logic                 core_clk,                   // System clock, 100 MHz.
    input  wire logic                 sys_rst,                    // Synchronous reset, high.
    input  wire logic                 low_power_osc_clock,        // 32.768 kHz pin, sampled.
    input  wire logic                 wireless_lan_power_on,      // Host power-on, WLAN side.
    input  wire logic                 short_range_radio_power_on, // Host power-on, radio side.
    input  wire logic                 external_wake_irq,          // External wake pin.
    input  wire logic                 host_sdio_resume,           // Host resume over SDIO.
    input  wire logic [PRS_NCORE-1:0] core_clock_request,         // Clock requests from cores.
    input  wire logic [31:0]          core_logic_state,           // Core state to retain.
    input  wire logic [7:0]           reg_addr,                   // Register word address.
    input  wire logic [31:0]          reg_wdata,                  // Register write data.
    input  wire logic                 reg_wr,                     // Write strobe.
    input  wire logic                 reg_rd,                     // Read strobe.
    output logic      [31:0]          reg_rdata,                  // Read data, next cycle.
    output prs_regulator_t            regulator_enable,           // Main regulator enables.
    output logic      [PRS_NRES-1:0]  resource_enable,            // Per-resource enables.
    output logic                      wlan_reset_n,               // WLAN section reset, low.
    output logic                      radio_reset_n,              // Radio section reset, low.
    output logic                      main_clock_enable,          // PLL and crystal run.
    output logic                      core_power_enable,          // Digital core powered.
    output logic                      state_save,                 // Pulse: state captured.
    output logic                      state_restore,              // Pulse: restore valid.
    output logic      [31:0]          restored_state,             // Retained core state.
    output logic                      io_tristate,                // All outputs floated.
    output logic                      input_disable               // Most inputs gated.
);
    localparam logic [PRS_NRES-1:0] BOOT_SET = `PRS_BOOT_SET;

    // Synchronisers for pins from outside the core clock domain.
    logic [1:0] sync_wl;
    logic [1:0] sync_sr;
    logic [1:0] sync_irq;
    logic [1:0] sync_sdio;
    logic [2:0] sync_lpo;

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            sync_wl   <= 2'h0;
            sync_sr   <= 2'h0;
            sync_irq  <= 2'h0;
            sync_sdio <= 2'h0;
            sync_lpo  <= 3'h0;
        end
        else
        begin
            sync_wl   <= {sync_wl[0], wireless_lan_power_on};
            sync_sr   <= {sync_sr[0], short_range_radio_power_on};
            sync_irq  <= {sync_irq[0], external_wake_irq};
            sync_sdio <= {sync_sdio[0], host_sdio_resume};
            sync_lpo  <= {sync_lpo[1:0], low_power_osc_clock};
        end
    end

    // Power-on decode and the sequencer tick from the low-power clock edge.
    wire wl_on     = sync_wl[1];
    wire sr_on     = sync_sr[1];
    wire any_on    = wl_on | sr_on;
    wire power_off = ~wl_on & ~sr_on;
    wire clr       = sys_rst | power_off;
    wire tick      = sync_lpo[1] & ~sync_lpo[2];

    // Configuration and state registers.
    logic [PRS_NRES-1:0] minimum_resource_set;
    logic [PRS_NRES-1:0] dep_table [PRS_NRES];
    prs_delay_t          delay_table [PRS_NRES];
    logic [PRS_NRES-1:0] clock_map [PRS_NCORE];
    logic [15:0]         req_timer;
    logic [PRS_NRES-1:0] req_timer_mask;
    logic [15:0]         wake_timer_load;
    logic [15:0]         wake_count;
    logic [PRS_NRES-1:0] resource_enabled_flag;
    logic [PRS_NRES-1:0] resource_transition_pending;
    logic [15:0]         res_timer [PRS_NRES];
    logic                was_off;
    logic [31:0]         retention_mem;
    prs_mode_t           mode;
    prs_mode_t           next_mode;

    // Write decode.
    wire wr_min   = reg_wr & (reg_addr == `PRS_ADDR_MIN_SET);
    wire wr_reqt  = reg_wr & (reg_addr == `PRS_ADDR_REQ_TIMER);
    wire wr_sleep = reg_wr & (reg_addr == `PRS_ADDR_SLEEP_CTRL);
    wire wr_wake  = reg_wr & (reg_addr == `PRS_ADDR_WAKE_TIMER);
    wire doze_req = wr_sleep & reg_wdata[`PRS_SLEEP_DOZE_BIT];
    wire deep_req = wr_sleep & reg_wdata[`PRS_SLEEP_DEEP_BIT];

    // Request sources combined into one raw request vector.
    logic [PRS_NRES-1:0] clk_req_set;
    always_comb
    begin
        clk_req_set = '0;
        for (int c = 0; c < PRS_NCORE; c++)
            if (core_clock_request[c])
                clk_req_set = clk_req_set | clock_map[c];
    end

    wire [PRS_NRES-1:0] timer_req = (req_timer != 16'h0000) ? req_timer_mask : '0;
    wire [PRS_NRES-1:0] base_req  = any_on ? `PRS_BASE_SET : '0;
    wire [PRS_NRES-1:0] raw_req   = clk_req_set | minimum_resource_set | timer_req | base_req;

    // Required set: requests closed over the dependency table.
    logic [PRS_NRES-1:0] required;
    always_comb
    begin
        required = raw_req;
        for (int k = 0; k < PRS_NRES; k++)
        begin
            for (int i = 0; i < PRS_NRES; i++)
            begin
                if (required[i])
                    required = required | dep_table[i];
            end
        end
    end

    // Dependency checks against the present resource status.
    wire [PRS_NRES-1:0] stable_on = resource_enabled_flag & ~resource_transition_pending;
    wire [PRS_NRES-1:0] powered   = resource_enabled_flag | resource_transition_pending;
    logic [PRS_NRES-1:0] deps_ok;
    logic [PRS_NRES-1:0] has_dependent;
    always_comb
    begin
        deps_ok       = '0;
        has_dependent = '0;
        for (int i = 0; i < PRS_NRES; i++)
        begin
            deps_ok[i] = (dep_table[i] & ~stable_on) == '0;
            for (int j = 0; j < PRS_NRES; j++)
            begin
                if (powered[j] && dep_table[j][i] && (j != i))
                    has_dependent[i] = 1'b1;
            end
        end
    end

    wire [PRS_NRES-1:0] start_on  = ~powered & required & deps_ok;
    wire [PRS_NRES-1:0] start_off = stable_on & ~required & ~has_dependent;

    // Per-resource state: enabled flag, pending flag and transition timer.
    for (genvar g = 0; g < PRS_NRES; g++)
    begin : g_res
        wire [15:0] don  = delay_table[g].enable_delay;
        wire [15:0] doff = delay_table[g].disable_delay;
        wire        boot = BOOT_SET[g];
        always_ff @(posedge core_clk)
        begin
            if (clr)
            begin
                resource_enabled_flag[g]       <= 1'b0;
                resource_transition_pending[g] <= 1'b0;
                res_timer[g]                   <= 16'h0000;
            end
            else if (was_off)
                resource_enabled_flag[g] <= boot;
            else if (tick && resource_transition_pending[g])
            begin
                res_timer[g] <= res_timer[g] - 16'h0001;
                if (res_timer[g] == 16'h0001)
                begin
                    resource_transition_pending[g] <= 1'b0;
                    resource_enabled_flag[g]       <= ~resource_enabled_flag[g];
                end
            end
            else if (tick && start_on[g])
            begin
                resource_enabled_flag[g]       <= (don == 16'h0000);
                resource_transition_pending[g] <= (don != 16'h0000);
                res_timer[g]                   <= don;
            end
            else if (tick && start_off[g])
            begin
                resource_enabled_flag[g]       <= (doff != 16'h0000);
                resource_transition_pending[g] <= (doff != 16'h0000);
                res_timer[g]                   <= doff;
            end
        end
    end

    // Power-up marker: high for one cycle after both inputs were low.
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            was_off <= 1'b0;
        else
            was_off <= power_off;
    end

    // Software registers; a shutdown reloads every default.
    always_ff @(posedge core_clk)
    begin
        if (clr)
        begin
            minimum_resource_set <= `PRS_MIN_SET_RST;
            wake_timer_load      <= `PRS_WAKE_TIMER_RST;
            for (int i = 0; i < PRS_NRES; i++)
            begin
                dep_table[i]   <= (i == 0) ? '0 : `PRS_DEP_RST;
                delay_table[i] <= {`PRS_DLY_OFF_RST, `PRS_DLY_ON_RST};
            end
            for (int c = 0; c < PRS_NCORE; c++)
                clock_map[c] <= `PRS_CLKMAP_RST;
        end
        else if (reg_wr)
        begin
            if (wr_min)
                minimum_resource_set <= reg_wdata[PRS_NRES-1:0];
            if (wr_wake)
                wake_timer_load <= reg_wdata[15:0];
            for (int i = 0; i < PRS_NRES; i++)
            begin
                if (reg_addr == `PRS_ADDR_DEP_BASE + 8'(i))
                    dep_table[i] <= reg_wdata[PRS_NRES-1:0];
                if (reg_addr == `PRS_ADDR_DELAY_BASE + 8'(i))
                    delay_table[i] <= reg_wdata;
            end
            for (int c = 0; c < PRS_NCORE; c++)
                if (reg_addr == `PRS_ADDR_CLKMAP_BASE + 8'(c))
                    clock_map[c] <= reg_wdata[PRS_NRES-1:0];
        end
    end

    // Resource request timer: requests its mask until it counts out.
    always_ff @(posedge core_clk)
    begin
        if (clr)
        begin
            req_timer      <= 16'h0000;
            req_timer_mask <= '0;
        end
        else if (wr_reqt)
        begin
            req_timer      <= reg_wdata[15:0];
            req_timer_mask <= reg_wdata[`PRS_REQT_MASK_LSB +: PRS_NRES];
        end
        else if (tick && req_timer != 16'h0000)
            req_timer <= req_timer - 16'h0001;
    end

    // Wake events; the timer counts on low-power ticks only while asleep.
    wire asleep = (mode == PRS_DOZE) || (mode == PRS_DEEP);
    prs_wake_t wake;
    assign wake.timer_expired = asleep & tick & (wake_count == 16'h0001);
    assign wake.external_irq  = sync_irq[1];
    assign wake.host_resume   = sync_sdio[1];
    wire wake_any = wake != '0;

    always_ff @(posedge core_clk)
    begin
        if (clr || !asleep)
            wake_count <= (wake_timer_load == 16'h0000) ? 16'h0001 : wake_timer_load;
        else if (tick && wake_count != 16'h0000)
            wake_count <= wake_count - 16'h0001;
    end

    // Power mode sequencing.
    always_comb
    begin
        next_mode = mode;
        case (mode)
            PRS_OFF:     next_mode = PRS_ACTIVE;
            PRS_ACTIVE:
            begin
                if (deep_req)
                    next_mode = PRS_SAVE;
                else if (doze_req)
                    next_mode = PRS_DOZE;
            end
            PRS_DOZE:    next_mode = wake_any ? PRS_ACTIVE : PRS_DOZE;
            PRS_SAVE:    next_mode = PRS_DEEP;
            PRS_DEEP:    next_mode = wake_any ? PRS_RESTORE : PRS_DEEP;
            PRS_RESTORE: next_mode = PRS_ACTIVE;
            default:     next_mode = PRS_OFF;
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (clr)
            mode <= PRS_OFF;
        else
            mode <= next_mode;
    end

    // Retention memory in the always-on domain; captured before the core powers off.
    always_ff @(posedge core_clk)
    begin
        if (clr)
            retention_mem <= 32'h0000_0000;
        else if (mode == PRS_SAVE)
            retention_mem <= core_logic_state;
    end

    // Registered outputs.
    always_ff @(posedge core_clk)
    begin
        if (clr)
        begin
            state_save     <= 1'b0;
            state_restore  <= 1'b0;
            restored_state <= 32'h0000_0000;
        end
        else
        begin
            state_save     <= (mode == PRS_SAVE);
            state_restore  <= (mode == PRS_RESTORE);
            restored_state <= (mode == PRS_RESTORE) ? retention_mem : restored_state;
        end
    end

    // Regulator, reset, clock and pad controls.
    assign resource_enable = any_on ? resource_enabled_flag : '0;
    assign regulator_enable.core_switching_regulator   = resource_enable[0];
    assign regulator_enable.core_linear_regulator      = resource_enable[1];
    assign regulator_enable.low_noise_linear_regulator = resource_enable[2];
    assign wlan_reset_n      = wl_on;
    assign radio_reset_n     = sr_on;
    assign main_clock_enable = any_on & (mode == PRS_ACTIVE || mode == PRS_RESTORE);
    assign core_power_enable = any_on & (mode != PRS_DEEP) & (mode != PRS_OFF);
    assign io_tristate       = power_off;
    assign input_disable     = power_off;

    // Read multiplexer; unmapped addresses read zero.
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (reg_addr)
            `PRS_ADDR_MIN_SET:    rd_mux = 32'(minimum_resource_set);
            `PRS_ADDR_STATUS:
            begin
                rd_mux[PRS_NRES-1:0] = resource_enabled_flag;
                rd_mux[`PRS_STAT_PEND_LSB +: PRS_NRES] = resource_transition_pending;
                rd_mux[`PRS_STAT_MODE_LSB +: 3] = mode;
            end
            `PRS_ADDR_REQ_TIMER:  rd_mux = {8'h00, req_timer_mask, req_timer};
            `PRS_ADDR_WAKE_TIMER: rd_mux = {16'h0000, wake_timer_load};
            `PRS_ADDR_RETAINED:   rd_mux = retention_mem;
            default:
            begin
                for (int i = 0; i < PRS_NRES; i++)
                begin
                    if (reg_addr == `PRS_ADDR_DEP_BASE + 8'(i))
                        rd_mux = 32'(dep_table[i]);
                    if (reg_addr == `PRS_ADDR_DELAY_BASE + 8'(i))
                        rd_mux = delay_table[i];
                end
                for (int c = 0; c < PRS_NCORE; c++)
                    if (reg_addr == `PRS_ADDR_CLKMAP_BASE + 8'(c))
                        rd_mux = 32'(clock_map[c]);
            end
        endcase
    end

    // Read data stands only in the cycle after the strobe.
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
            reg_rdata <= 32'h0000_0000;
        else
            reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
endmodule // prs_resource_sequencer
`default_nettype wire

// file: prs_resource_sequencer_bench.sv
// Self-checking bench for the resource sequencer.
`default_nettype none
module prs_resource_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk = 1'b0, sys_rst = 1'b1, low_power_osc_clock = 1'b0, reg_wr = 1'b0;
    logic        reg_rd = 1'b0, external_wake_irq = 1'b0, host_sdio_resume = 1'b0;
    logic        wireless_lan_power_on, short_range_radio_power_on, wlan_reset_n, radio_reset_n;
    logic        main_clock_enable, core_power_enable, state_save, state_restore;
    logic        io_tristate, input_disable;
    logic [1:0]  core_clock_request = 2'b00, want = 2'b00;
    logic [3:0]  lag = 4'h2;
    logic [7:0]  reg_addr = 8'h00, resource_enable;
    logic [31:0] core_logic_state = 32'h0, reg_wdata = 32'h0, reg_rdata, restored_state, d, st;
    prs_pkg::prs_regulator_t regulator_enable;
    int          n_mismatch = 0, n_tests = 0, cycles = 0, on, off;
    logic [7:0]  ta [8] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h09, 8'h10, 8'h18, 8'h06};
    logic [31:0] te [8] = '{32'h7, 32'h10007, 32'h0, 32'h20, 32'h1, 32'h10002, 32'h6, 32'h0};
    prs_host_model i_prs_host_model (.core_clk, .want, .lag, .wl_on(wireless_lan_power_on),
        .sr_on(short_range_radio_power_on));
    prs_resource_sequencer i_prs_resource_sequencer (.core_clk, .sys_rst, .low_power_osc_clock,
        .wireless_lan_power_on, .short_range_radio_power_on, .external_wake_irq, .host_sdio_resume,
        .core_clock_request, .core_logic_state, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .regulator_enable, .resource_enable, .wlan_reset_n, .radio_reset_n, .main_clock_enable,
        .core_power_enable, .state_save, .state_restore, .restored_state, .io_tristate,
        .input_disable);
    // Core clock at 100 MHz and a tick pin of 16 core cycles, off the rising core edges.
    // The slow pin lets three bus cycles after a tick land before the next pin rise.
    always #5 core_clk = ~core_clk;
    always #80 low_power_osc_clock = ~low_power_osc_clock;
    // Cuts a hang short.
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 8000)
        begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // One register cycle: a write, or a read whose data land in d.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
        @(posedge core_clk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, v};
        @(posedge core_clk);
        {reg_wr, reg_rd} <= 2'b00;
        #1 d = reg_rdata;
    endtask
    // Waits n sequencer ticks, ending well clear of the next one.
    task automatic tk(input int n);
        repeat (n)
        begin
            @(posedge low_power_osc_clock);
            repeat (5) @(posedge core_clk);
        end
    endtask
    task automatic cy(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Power-up, registers, resource timing, requests, sleep and shutdown.
    initial
    begin
        void'($urandom(32'h8cf3));
        lag = 4'($urandom);
        cy(4);
        sys_rst <= 1'b0;
        want <= 2'b01;
        cy(30);
        chk({regulator_enable, wlan_reset_n, radio_reset_n}, 5'b11101);
        bus(1'b1, 8'h01, $urandom);
        bus(1'b1, 8'h06, $urandom);
        for (int i = 0; i < 8; i++)
        begin
            bus(1'b0, ta[i], 32'h0);
            chk(d, te[i]);
        end
        want <= 2'b11;
        cy(25);
        want <= 2'b10;
        cy(25);
        chk({regulator_enable, wlan_reset_n, radio_reset_n}, 5'b11110);
        $display("Test power and registers done");
        for (int r = 3; r < 7; r++)
        begin
            on = (r == 3) ? 0 : 1 + $urandom % 3;
            off = (r == 4) ? 0 : 1 + $urandom % 3;
            bus(1'b1, 8'h10 + r[7:0], {off[15:0], on[15:0]});
            tk(1);
            bus(1'b1, 8'h00, 32'h7 | (32'h1 << r));
            tk(1);
            bus(1'b0, 8'h01, 32'h0);
            chk({d[8 + r], d[r]}, {on != 0, on == 0});
            tk(on);
            bus(1'b0, 8'h01, 32'h0);
            chk({d[8 + r], d[r], resource_enable[r]}, 3'b011);
            bus(1'b1, 8'h00, 32'h7);
            tk(1);
            bus(1'b0, 8'h01, 32'h0);
            chk({d[8 + r], d[r]}, {off != 0, off != 0});
            tk(off);
            bus(1'b0, 8'h01, 32'h0);
            chk({d[8 + r], d[r]}, 2'b00);
        end
        bus(1'b1, 8'h18, 32'h80);
        core_clock_request <= 2'b01;
        tk(4);
        bus(1'b0, 8'h01, 32'h0);
        chk(d[7], 1'b1);
        core_clock_request <= 2'b00;
        bus(1'b1, 8'h02, 32'h0080_0005);
        bus(1'b0, 8'h02, 32'h0);
        chk(d, 32'h0080_0005);
        tk(2);
        bus(1'b0, 8'h01, 32'h0);
        chk(d[7], 1'b1);
        $display("Test resource timing done");
        bus(1'b1, 8'h03, 32'h1);
        cy(4);
        chk(main_clock_enable, 1'b0);
        host_sdio_resume <= 1'b1;
        cy(8);
        chk(main_clock_enable, 1'b1);
        host_sdio_resume <= 1'b0;
        cy(6);
        st = $urandom;
        core_logic_state <= st;
        bus(1'b1, 8'h03, 32'h2);
        cy(4);
        chk(core_power_enable, 1'b0);
        external_wake_irq <= 1'b1;
        repeat (20)
        begin
            cy(1);
            if (state_restore === 1'b1) break;
        end
        chk(restored_state, st);
        external_wake_irq <= 1'b0;
        $display("Test sleep modes done");
        bus(1'b1, 8'h00, 32'hf);
        want <= 2'b00;
        cy(25);
        chk({io_tristate, input_disable, regulator_enable, resource_enable}, 13'h1800);
        want <= 2'b10;
        cy(30);
        bus(1'b0, 8'h00, 32'h0);
        chk(d, 32'h7);
        $display("Test shutdown done");
        report_and_stop();
    end
endmodule // prs_resource_sequencer_bench
`default_nettype wire

// file: prs_resource_sequencer_checker.sv
// Port assertions for the resource sequencer.
`default_nettype none
module prs_resource_sequencer_checker
    import prs_pkg::*;
(
    input wire logic           core_clk,                   // Clock.
    input wire logic           sys_rst,                    // Reset.
    input wire logic           wireless_lan_power_on,      // WLAN on.
    input wire logic           short_range_radio_power_on, // Radio on.
    input wire prs_regulator_t regulator_enable,           // Regulators.
    input wire logic [7:0]     resource_enable,            // Resources.
    input wire logic           wlan_reset_n,               // WLAN reset.
    input wire logic           radio_reset_n,              // Radio reset.
    input wire logic           main_clock_enable,          // Clocks.
    input wire logic           core_power_enable,          // Core power.
    input wire logic           state_save,                 // Save pulse.
    input wire logic           state_restore,              // Restore pulse.
    input wire logic           io_tristate,                // Floated.
    input wire logic           input_disable               // Gated.
);
    // All checks use the core clock and stand idle in reset.
    default clocking chk_cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    reg_map_a: assert property (regulator_enable ==
        {resource_enable[0], resource_enable[1], resource_enable[2]}) else $error("Bad map.");
    all_off_a: assert property (io_tristate |-> regulator_enable == 3'b000 && !resource_enable)
        else $error("On in shutdown.");
    one_on_a: assert property ((wireless_lan_power_on || short_range_radio_power_on) [*5]
        |-> !io_tristate) else $error("Shut with one input.");
    off_gate_a: assert property ((!wireless_lan_power_on && !short_range_radio_power_on) [*5]
        |-> io_tristate && input_disable) else $error("Pins not floated.");
    wl_held_a: assert property ((!wireless_lan_power_on) [*5] |-> !wlan_reset_n)
        else $error("WLAN out of reset.");
    wl_run_a: assert property (wireless_lan_power_on [*5] |-> wlan_reset_n)
        else $error("WLAN held.");
    radio_run_a: assert property (short_range_radio_power_on [*5] |-> radio_reset_n)
        else $error("Radio held.");
    boot_regs_a: assert property ($fell(io_tristate) |-> ##[1:3] regulator_enable == 3'b111)
        else $error("No boot.");
    save_first_a: assert property ($fell(core_power_enable) && !io_tristate |-> state_save)
        else $error("Core off unsaved.");
    restore_on_a: assert property (state_restore |-> core_power_enable && main_clock_enable)
        else $error("Restore unpowered.");
endmodule // prs_resource_sequencer_checker
bind prs_resource_sequencer prs_resource_sequencer_checker i_prs_resource_sequencer_checker (
    .core_clk, .sys_rst, .wireless_lan_power_on, .short_range_radio_power_on, .regulator_enable,
    .resource_enable, .wlan_reset_n, .radio_reset_n, .main_clock_enable, .core_power_enable,
    .state_save, .state_restore, .io_tristate, .input_disable);
`default_nettype wire
